// *** inc/sfr_defs.svh ***
// sfr_defs.svh: register offsets, opcodes, field positions, reset values and counts
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH
// register byte offsets on the apb bus
`define SFR_OFF_CTRL   8'h00
`define SFR_OFF_STAT   8'h04
`define SFR_OFF_FLAG   8'h08
`define SFR_OFF_NVCR   8'h0c
`define SFR_OFF_VCR    8'h10
`define SFR_OFF_EVCR   8'h14
`define SFR_OFF_EAR    8'h18
`define SFR_OFF_STATE  8'h1c
// control register fields
`define SFR_CTRL_PROTO_LSB 0
`define SFR_CTRL_ADDR4_BIT 2
`define SFR_CTRL_DUMMY_LSB 4
// protocol codes: dual equals log2 of its line count; bad is the unused code, run as single line
`define SFR_PROTO_DUAL 2'h1
`define SFR_PROTO_BAD  2'h3
// reset values
`define SFR_CTRL_RST   8'h80
`define SFR_STAT_RST   8'h00
`define SFR_FLAG_RST   8'h80
`define SFR_NVCR_RST   16'hffff
`define SFR_VCR_RST    8'hfb
`define SFR_EVCR_RST   8'hff
`define SFR_EAR_RST    8'h00
`define SFR_NVCR_RSVD  16'h0010
// bit and clock counts
`define SFR_CMD_BITS   6'h08
`define SFR_ADDR3_BITS 6'h18
`define SFR_ADDR4_BITS 6'h20
`define SFR_WORD_DUMMY 4'h4
// opcodes
`define SFR_OP_READ    8'h03
`define SFR_OP_READ4   8'h13
`define SFR_OP_FAST    8'h0b
`define SFR_OP_FAST4   8'h0c
`define SFR_OP_DOUT    8'h3b
`define SFR_OP_DOUT4   8'h3c
`define SFR_OP_DIO     8'hbb
`define SFR_OP_DIO4    8'hbc
`define SFR_OP_QOUT    8'h6b
`define SFR_OP_QOUT4   8'h6c
`define SFR_OP_QIO     8'heb
`define SFR_OP_QIO4    8'hec
`define SFR_OP_WORD    8'he7
`define SFR_OP_DTR     8'h0d
`define SFR_OP_DTR4    8'h0e
`define SFR_OP_DDOUT   8'h3d
`define SFR_OP_DDIO    8'hbd
`define SFR_OP_DDIO4   8'hbe
`define SFR_OP_DQOUT   8'h6d
`define SFR_OP_DQIO    8'hed
`define SFR_OP_DQIO4   8'hee
`define SFR_OP_WREN    8'h06
`define SFR_OP_WRDI    8'h04
`define SFR_OP_CLRFLAG 8'h50
`define SFR_OP_RDSR    8'h05
`define SFR_OP_RDFLAG  8'h70
`define SFR_OP_RDNV    8'hb5
`define SFR_OP_RDVC    8'h85
`define SFR_OP_RDEV    8'h65
`define SFR_OP_RDEA    8'hc8
`endif

// *** inc/sfr_pkg.sv ***
// sfr_pkg.sv: state and command attribute types
package sfr_pkg;
	typedef enum logic [2:0] {SFR_CMD, SFR_ADDR, SFR_DUMMY, SFR_DATA, SFR_HOLD, SFR_SKIP} sfr_state_t;
	typedef struct packed {
		logic       known;    // opcode accepted in this protocol
		logic       rd_array; // array read with address phase
		logic       rd_reg;   // register read
		logic       a4;       // four byte address opcode
		logic [1:0] alw;      // log2 address lines
		logic       adtr;     // address on both edges
		logic [1:0] dlw;      // log2 data lines
		logic       ddtr;     // data on both edges
		logic [1:0] dum;      // 0 none, 1 configured, 2 fixed four
	} sfr_attr_t;
endpackage

// *** inc/sfr_pins_if.sv ***
// sfr_pins_if.sv: synchronised link pins and edge events
`timescale 1ns/1ps
interface sfr_pins_if;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_n;
	logic       cs_rise;
	logic [3:0] dq;
	modport src (output sck_rise, sck_fall, cs_n, cs_rise, dq);
	modport dst (input sck_rise, sck_fall, cs_n, cs_rise, dq);
endinterface

// *** logic/sfr_pin_sync.sv ***
// sfr_pin_sync.sv: two-stage synchroniser and edge finder for the link pins
`timescale 1ns/1ps
module sfr_pin_sync (
	input  wire logic       clk_in,    // system clock
	input  wire logic       arst_n_in, // async reset, active low
	input  wire logic       sck_in,    // serial clock pin
	input  wire logic       cs_n_in,   // chip select pin, active low
	input  wire logic [3:0] dq_in,     // data pins
	sfr_pins_if.src         pins_out   // synchronised pins and events
);
	logic [5:0] s1;
	logic [5:0] s2;
	logic [1:0] s3;

	// s1 feeds only s2; edges come from s2 against s3
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1 <= 6'h10;
			s2 <= 6'h10;
			s3 <= 2'h1;
		end else begin
			s1 <= {sck_in, cs_n_in, dq_in};
			s2 <= s1;
			s3 <= s2[5:4];
		end
	end

	// edge events, one cycle each
	assign pins_out.sck_rise = s2[5] & ~s3[1];
	assign pins_out.sck_fall = ~s2[5] & s3[1];
	assign pins_out.cs_n     = s2[4];
	assign pins_out.cs_rise  = s2[4] & ~s3[0];
	assign pins_out.dq       = s2[3:0];
endmodule

// *** logic/sfr_core.sv ***
// sfr_core.sv: serial flash command front end for array reads, write latch and register reads
`timescale 1ns/1ps
`include "sfr_defs.svh"
module sfr_core (
	input  wire logic        CLK_IN,         // 50 MHz system clock
	input  wire logic        ARST_N_IN,      // async reset, active low
	input  wire logic        SCK_IN,         // serial clock from host
	input  wire logic        CS_N_IN,        // chip select, active low
	input  wire logic [3:0]  DQ_IN,          // data pins as seen on the wire
	output logic      [3:0]  DQ_OUT,         // data pin drive values
	output logic      [3:0]  DQ_OE_OUT,      // data pin enables, high drives
	output logic      [31:0] MEM_ADDR_OUT,   // array byte address
	input  wire logic [7:0]  MEM_DATA_IN,    // array byte at MEM_ADDR_OUT
	input  wire logic        BUSY_IN,        // program or erase in progress
	input  wire logic        PROT_ERR_SET_IN,// protection error event
	output logic             WEL_OUT,        // write enable latch
	input  wire logic        PSEL_IN,        // apb select
	input  wire logic        PENABLE_IN,     // apb enable
	input  wire logic        PWRITE_IN,      // apb direction
	input  wire logic [7:0]  PADDR_IN,       // apb byte address
	input  wire logic [31:0] PWDATA_IN,      // apb write data
	output logic      [31:0] PRDATA_OUT,     // apb read data
	output logic             PREADY_OUT,     // apb ready
	output logic             PSLVERR_OUT     // apb error on unmapped address
);
	sfr_pins_if pi ();

	sfr_pin_sync u_sync (
		.clk_in    (CLK_IN),
		.arst_n_in (ARST_N_IN),
		.sck_in    (SCK_IN),
		.cs_n_in   (CS_N_IN),
		.dq_in     (DQ_IN),
		.pins_out  (pi)
	);

	// software-visible registers
	logic [7:0]  ctrl;
	logic [7:0]  stat;
	logic [7:0]  flag;
	logic [15:0] nvcr;
	logic [7:0]  vcr;
	logic [7:0]  evcr;
	logic [7:0]  ear;
	logic        wel;
	logic        prot_err;
	logic [31:0] prdata;

	// link state
	sfr_pkg::sfr_state_t state;
	sfr_pkg::sfr_state_t next_state;
	sfr_pkg::sfr_attr_t  attr;
	sfr_pkg::sfr_attr_t  next_attr;
	sfr_pkg::sfr_attr_t  cmd_attr;
	logic [5:0]  cnt;
	logic [5:0]  next_cnt;
	logic [7:0]  opc;
	logic [7:0]  next_opc;
	logic [31:0] addr;
	logic [31:0] next_addr;
	logic [7:0]  sh;
	logic [7:0]  next_sh;
	logic [2:0]  ocnt;
	logic [2:0]  next_ocnt;
	logic [1:0]  nvb;
	logic [1:0]  next_nvb;
	logic        run;
	logic        next_run;
	logic [3:0]  dq_q;
	logic [3:0]  next_dq;
	logic [3:0]  oe_q;
	logic [3:0]  next_oe;

	// command attributes by opcode and protocol width
	function automatic sfr_pkg::sfr_attr_t decode(input logic [7:0] o, input logic [1:0] lw);
		sfr_pkg::sfr_attr_t a;
		a = '0;
		a.known = 1'b1;
		a.rd_array = 1'b1;
		a.alw = lw;
		a.dlw = lw;
		a.dum = 2'h1;
		case (o)
			`SFR_OP_READ, `SFR_OP_READ4: a.dum = 2'h0;
			`SFR_OP_FAST, `SFR_OP_FAST4: a.dum = 2'h1;
			`SFR_OP_DOUT, `SFR_OP_DOUT4: a.dlw = 2'h1;
			`SFR_OP_DIO, `SFR_OP_DIO4: begin
				a.alw = 2'h1;
				a.dlw = 2'h1;
			end
			`SFR_OP_QOUT, `SFR_OP_QOUT4: a.dlw = 2'h2;
			`SFR_OP_QIO, `SFR_OP_QIO4: begin
				a.alw = 2'h2;
				a.dlw = 2'h2;
			end
			`SFR_OP_WORD: begin
				a.known = (lw != `SFR_PROTO_DUAL);
				a.alw = 2'h2;
				a.dlw = 2'h2;
				a.dum = 2'h2;
			end
			`SFR_OP_DTR, `SFR_OP_DTR4: begin
				a.adtr = 1'b1;
				a.ddtr = 1'b1;
			end
			`SFR_OP_DDOUT: begin
				a.adtr = 1'b1;
				a.ddtr = 1'b1;
				a.dlw = 2'h1;
			end
			`SFR_OP_DDIO, `SFR_OP_DDIO4: begin
				a.adtr = 1'b1;
				a.ddtr = 1'b1;
				a.alw = 2'h1;
				a.dlw = 2'h1;
			end
			`SFR_OP_DQOUT: begin
				a.adtr = 1'b1;
				a.ddtr = 1'b1;
				a.dlw = 2'h2;
			end
			`SFR_OP_DQIO, `SFR_OP_DQIO4: begin
				a.adtr = 1'b1;
				a.ddtr = 1'b1;
				a.alw = 2'h2;
				a.dlw = 2'h2;
			end
			`SFR_OP_RDSR, `SFR_OP_RDFLAG, `SFR_OP_RDNV,
			`SFR_OP_RDVC, `SFR_OP_RDEV, `SFR_OP_RDEA: begin
				a.rd_array = 1'b0;
				a.rd_reg = 1'b1;
				a.dum = 2'h0;
			end
			`SFR_OP_WREN, `SFR_OP_WRDI, `SFR_OP_CLRFLAG: begin
				a.rd_array = 1'b0;
				a.dum = 2'h0;
			end
			default: begin
				a.known = 1'b0;
				a.rd_array = 1'b0;
			end
		endcase
		case (o)
			`SFR_OP_READ4, `SFR_OP_FAST4, `SFR_OP_DOUT4, `SFR_OP_DIO4, `SFR_OP_QOUT4,
			`SFR_OP_QIO4, `SFR_OP_DTR4, `SFR_OP_DDIO4, `SFR_OP_DQIO4: a.a4 = 1'b1;
			default: a.a4 = 1'b0;
		endcase
		return a;
	endfunction

	// shift one sample of 1, 2 or 4 lines into a word
	function automatic logic [31:0] shin(input logic [31:0] v, input logic [1:0] w,
		input logic [3:0] d);
		case (w)
			2'h0: shin = {v[30:0], d[0]};
			2'h1: shin = {v[29:0], d[1:0]};
			default: shin = {v[27:0], d};
		endcase
	endfunction

	// protocol, step sizes and phase ends
	wire [1:0]  lw        = (ctrl[`SFR_CTRL_PROTO_LSB +: 2] == `SFR_PROTO_BAD) ? 2'h0 :
		ctrl[`SFR_CTRL_PROTO_LSB +: 2];
	wire [31:0] cmd_word  = shin({24'h0, opc}, lw, pi.dq);
	wire [31:0] addr_sh   = shin(addr, attr.alw, pi.dq);
	wire [5:0]  cstep     = 6'h1 << lw;
	wire [5:0]  astep     = 6'h1 << attr.alw;
	wire [5:0]  abits     = (attr.a4 | ctrl[`SFR_CTRL_ADDR4_BIT]) ? `SFR_ADDR4_BITS :
		`SFR_ADDR3_BITS;
	wire        cmd_last  = (cnt + cstep) == `SFR_CMD_BITS;
	wire        addr_last = (cnt + astep) == abits;
	// the fall that closes the last command clock is not an address edge
	wire        a_ev      = pi.sck_rise | (attr.adtr & pi.sck_fall & (cnt != 6'h0));
	wire        o_ev      = pi.sck_fall | (attr.ddtr & run & pi.sck_rise);
	wire [3:0]  ndum      = (attr.dum == 2'h0) ? 4'h0 :
		(attr.dum == 2'h2) ? `SFR_WORD_DUMMY : ctrl[`SFR_CTRL_DUMMY_LSB +: 4];
	wire        dum_last  = (cnt[3:0] + 4'h1) == ndum;
	assign cmd_attr = decode(cmd_word[7:0], lw);

	// register bytes seen on the link
	wire [7:0]  sr_byte   = {stat[7:2], wel, BUSY_IN};
	wire [7:0]  fl_byte   = {flag[7:2], prot_err, flag[0]};
	wire [15:0] nv_rd     = nvcr | `SFR_NVCR_RSVD;
	wire [7:0]  nv_byte   = (nvb == 2'h0) ? nv_rd[7:0] :
		(nvb == 2'h1) ? nv_rd[15:8] : 8'h00;
	wire [7:0]  reg_byte  = (opc == `SFR_OP_RDSR) ? sr_byte :
		(opc == `SFR_OP_RDFLAG) ? fl_byte :
		(opc == `SFR_OP_RDNV) ? nv_byte :
		(opc == `SFR_OP_RDVC) ? vcr :
		(opc == `SFR_OP_RDEV) ? evcr : ear;
	wire [7:0]  src_byte  = attr.rd_array ? MEM_DATA_IN : reg_byte;

	// output chunk: top bits of the byte, placed on the active lines
	wire        load      = (ocnt == 3'h0);
	wire [7:0]  obyte     = load ? src_byte : sh;
	wire [3:0]  chunk     = (attr.dlw == 2'h0) ? {2'h0, obyte[7], 1'b0} :
		(attr.dlw == 2'h1) ? {2'h0, obyte[7:6]} : obyte[7:4];
	wire [3:0]  oe_mask   = (attr.dlw == 2'h0) ? 4'h2 :
		(attr.dlw == 2'h1) ? 4'h3 : 4'hf;
	wire [7:0]  shv       = (attr.dlw == 2'h0) ? {obyte[6:0], 1'b0} :
		(attr.dlw == 2'h1) ? {obyte[5:0], 2'h0} : {obyte[3:0], 4'h0};
	wire [2:0]  chunks_m1 = (attr.dlw == 2'h0) ? 3'h7 : (attr.dlw == 2'h1) ? 3'h3 : 3'h1;

	// single-byte commands run only when select rises in the hold state
	wire        exec      = pi.cs_rise & (state == sfr_pkg::SFR_HOLD);
	wire        set_wel   = exec & (opc == `SFR_OP_WREN);
	wire        clr_flag  = exec & (opc == `SFR_OP_CLRFLAG);
	wire        clr_wel   = (exec & (opc == `SFR_OP_WRDI) & ~prot_err) | clr_flag;

	// link sequencer next state
	always_comb begin
		next_state = state;
		next_attr = attr;
		next_cnt = cnt;
		next_opc = opc;
		next_addr = addr;
		next_sh = sh;
		next_ocnt = ocnt;
		next_nvb = nvb;
		next_run = run;
		next_dq = dq_q;
		next_oe = oe_q;
		if (pi.cs_n) begin
			next_state = sfr_pkg::SFR_CMD;
			next_cnt = 6'h0;
			next_run = 1'b0;
			next_ocnt = 3'h0;
			next_oe = 4'h0;
		end else begin
			case (state)
				sfr_pkg::SFR_CMD: begin
					if (pi.sck_rise) begin
						next_opc = cmd_word[7:0];
						next_cnt = cnt + cstep;
						if (cmd_last) begin
							next_cnt = 6'h0;
							next_attr = cmd_attr;
							next_addr = 32'h0;
							next_nvb = 2'h0;
							if (!cmd_attr.known)
								next_state = sfr_pkg::SFR_SKIP;
							else if (cmd_attr.rd_array)
								next_state = sfr_pkg::SFR_ADDR;
							else if (cmd_attr.rd_reg)
								next_state = sfr_pkg::SFR_DATA;
							else
								next_state = sfr_pkg::SFR_HOLD;
						end
					end
				end
				sfr_pkg::SFR_ADDR: begin
					if (a_ev) begin
						next_addr = addr_sh;
						next_cnt = cnt + astep;
						if (addr_last) begin
							next_cnt = 6'h0;
							if (attr.dum == 2'h2)
								next_addr[0] = 1'b0;
							next_state = (ndum == 4'h0) ? sfr_pkg::SFR_DATA :
								sfr_pkg::SFR_DUMMY;
						end
					end
				end
				sfr_pkg::SFR_DUMMY: begin
					if (pi.sck_rise) begin
						next_cnt = cnt + 6'h1;
						if (dum_last)
							next_state = sfr_pkg::SFR_DATA;
					end
				end
				sfr_pkg::SFR_DATA: begin
					if (o_ev) begin
						next_run = 1'b1;
						next_oe = oe_mask;
						next_dq = chunk;
						next_sh = shv;
						next_ocnt = load ? chunks_m1 : ocnt - 3'h1;
						if (load & attr.rd_array)
							next_addr = addr + 32'h1;
						if (load & attr.rd_reg & (nvb != 2'h2))
							next_nvb = nvb + 2'h1;
					end
				end
				sfr_pkg::SFR_HOLD: begin
					if (pi.sck_rise)
						next_state = sfr_pkg::SFR_SKIP;
				end
				default: next_state = sfr_pkg::SFR_SKIP;
			endcase
		end
	end

	// link sequencer registers
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state <= sfr_pkg::SFR_CMD;
			attr <= '0;
			cnt <= 6'h0;
			opc <= 8'h00;
			addr <= 32'h0;
			sh <= 8'h00;
			ocnt <= 3'h0;
			nvb <= 2'h0;
			run <= 1'b0;
			dq_q <= 4'h0;
			oe_q <= 4'h0;
		end else begin
			state <= next_state;
			attr <= next_attr;
			cnt <= next_cnt;
			opc <= next_opc;
			addr <= next_addr;
			sh <= next_sh;
			ocnt <= next_ocnt;
			nvb <= next_nvb;
			run <= next_run;
			dq_q <= next_dq;
			oe_q <= next_oe;
		end
	end

	// write enable latch and protection error flag; the error set wins over its clear
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			wel <= 1'b0;
			prot_err <= 1'b0;
		end else begin
			if (set_wel)
				wel <= 1'b1;
			else if (clr_wel)
				wel <= 1'b0;
			if (PROT_ERR_SET_IN)
				prot_err <= 1'b1;
			else if (clr_flag)
				prot_err <= 1'b0;
		end
	end

	// apb decode and read mux
	wire        apb_setup = PSEL_IN & ~PENABLE_IN;
	wire        apb_acc   = PSEL_IN & PENABLE_IN;
	wire        hit_ctrl  = PADDR_IN == `SFR_OFF_CTRL;
	wire        hit_stat  = PADDR_IN == `SFR_OFF_STAT;
	wire        hit_flag  = PADDR_IN == `SFR_OFF_FLAG;
	wire        hit_nvcr  = PADDR_IN == `SFR_OFF_NVCR;
	wire        hit_vcr   = PADDR_IN == `SFR_OFF_VCR;
	wire        hit_evcr  = PADDR_IN == `SFR_OFF_EVCR;
	wire        hit_ear   = PADDR_IN == `SFR_OFF_EAR;
	wire        hit_state = PADDR_IN == `SFR_OFF_STATE;
	wire        hit       = hit_ctrl | hit_stat | hit_flag | hit_nvcr | hit_vcr |
		hit_evcr | hit_ear | hit_state;
	wire        apb_wr    = apb_acc & PWRITE_IN;
	wire [31:0] rd_mux    = hit_ctrl ? {24'h0, ctrl} :
		hit_stat ? {24'h0, sr_byte} :
		hit_flag ? {24'h0, fl_byte} :
		hit_nvcr ? {16'h0, nvcr} :
		hit_vcr ? {24'h0, vcr} :
		hit_evcr ? {24'h0, evcr} :
		hit_ear ? {24'h0, ear} :
		hit_state ? {29'h0, BUSY_IN, prot_err, wel} : 32'h0;

	// apb register writes, taken in the access cycle
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ctrl <= `SFR_CTRL_RST;
			stat <= `SFR_STAT_RST;
			flag <= `SFR_FLAG_RST;
			nvcr <= `SFR_NVCR_RST;
			vcr <= `SFR_VCR_RST;
			evcr <= `SFR_EVCR_RST;
			ear <= `SFR_EAR_RST;
		end else if (apb_wr) begin
			if (hit_ctrl)
				ctrl <= PWDATA_IN[7:0];
			if (hit_stat)
				stat <= PWDATA_IN[7:0];
			if (hit_flag)
				flag <= PWDATA_IN[7:0];
			if (hit_nvcr)
				nvcr <= PWDATA_IN[15:0];
			if (hit_vcr)
				vcr <= PWDATA_IN[7:0];
			if (hit_evcr)
				evcr <= PWDATA_IN[7:0];
			if (hit_ear)
				ear <= PWDATA_IN[7:0];
		end
	end

	// read data captured in the setup cycle, stable through the access cycle
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN)
			prdata <= 32'h0;
		else if (apb_setup)
			prdata <= rd_mux;
	end

	// outputs
	assign PRDATA_OUT   = prdata;
	assign PREADY_OUT   = 1'b1;
	assign PSLVERR_OUT  = apb_acc & ~hit;
	assign DQ_OUT       = dq_q;
	assign DQ_OE_OUT    = oe_q;
	assign MEM_ADDR_OUT = addr;
	assign WEL_OUT      = wel;
endmodule

// *** verification/sfr_host_model.sv ***
// sfr_host_model.sv: behavioural spi host framing commands for the flash front end
`timescale 1ns/1ps
module sfr_host_model (
	output logic            sck_out,   // serial clock, low outside frames
	output logic            cs_n_out,  // chip select, active low
	output logic      [3:0] dq_out,    // host drive values
	output logic      [3:0] dq_oe_out, // host drive enables
	input  wire logic [3:0] dq_in      // resolved wire levels
);
	// idle: clock parked low, select high, lines released
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		dq_out = 4'h0;
		dq_oe_out = 4'h0;
	end
	// open a frame off the system clock phase
	task open_f();
		#7 cs_n_out = 1'b0;
		#80;
	endtask
	// close a frame, lines released, select high long enough to be seen
	task close_f();
		#80 cs_n_out = 1'b1;
		dq_oe_out = 4'h0;
		#320;
	endtask
	// shift the top nb bits of v out on 2**lw lines, msb first, both edges if dtr
	task put(input logic [31:0] v, input int nb, input int lw, input bit dtr);
		int w;
		logic [31:0] s;
		w = 1 << lw;
		s = v;
		dq_oe_out = 4'((1 << w) - 1);
		// double-edge: lines settle half way between edges, first edge a rise
		if (dtr) #40;
		for (int i = 0; i < nb; i += w) begin
			dq_out = 4'(s[31:28] >> (4 - w));
			s = s << w;
			if (dtr) begin
				#40 sck_out = ~sck_out;
				#40;
			end else begin
				#80 sck_out = 1'b1;
				#80 sck_out = 1'b0;
			end
		end
	endtask
	// clocks with the lines released
	task dummy(input int n);
		dq_oe_out = 4'h0;
		repeat (n) begin
			#80 sck_out = 1'b1;
			#80 sck_out = 1'b0;
		end
	endtask
	// take one byte on 2**lw lines, single-line output on io_line_1
	task get(output logic [7:0] b, input int lw);
		int w;
		w = 1 << lw;
		b = 8'h00;
		dq_oe_out = 4'h0;
		for (int i = 0; i < 8; i += w) begin
			#80 sck_out = 1'b1;
			#20 b = (b << w) | 8'(lw == 0 ? {3'h0, dq_in[1]} : dq_in & 4'((1 << w) - 1));
			#60 sck_out = 1'b0;
		end
	endtask
endmodule

// *** verification/sfr_core_sva.sv ***
// sfr_core_sva.sv: port-level checks on the flash front end
`timescale 1ns/1ps
module sfr_core_sva (
	input wire logic        CLK_IN,       // system clock
	input wire logic        ARST_N_IN,    // reset, active low
	input wire logic        CS_N_IN,      // chip select
	input wire logic [3:0]  DQ_OE_OUT,    // pin enables
	input wire logic [31:0] MEM_ADDR_OUT, // array address
	input wire logic        WEL_OUT,      // write latch
	input wire logic        PSEL_IN,      // apb select
	input wire logic        PENABLE_IN,   // apb enable
	input wire logic [7:0]  PADDR_IN,     // apb address
	input wire logic [31:0] PRDATA_OUT,   // apb read data
	input wire logic        PREADY_OUT,   // apb ready
	input wire logic        PSLVERR_OUT   // apb error
);
	default clocking dc @(posedge CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);
	a_ready_always: assert property (PREADY_OUT) else $error("pready low");
	a_err_unmapped: assert property (PSEL_IN && PENABLE_IN && PADDR_IN > 8'h1c |-> PSLVERR_OUT)
		else $error("unmapped access without error");
	a_err_zero_data: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN && PRDATA_OUT == 32'h0)
		else $error("error outside access or with data");
	a_wel_set_cause: assert property ($rose(WEL_OUT) |-> CS_N_IN && !$past(CS_N_IN, 6))
		else $error("latch set without a closed frame");
	a_wel_fall_cause: assert property ($fell(WEL_OUT) |-> CS_N_IN)
		else $error("latch cleared inside a frame");
	a_wel_frame_hold: assert property ((!CS_N_IN) [*5] |-> $stable(WEL_OUT))
		else $error("latch moved while selected");
	a_oe_idle_off: assert property (CS_N_IN [*5] |-> DQ_OE_OUT == 4'h0)
		else $error("pins driven while deselected");
	a_oe_line_sets: assert property (DQ_OE_OUT inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("illegal output line set");
	a_oe_start_sel: assert property ($rose(|DQ_OE_OUT) |-> !CS_N_IN && !$past(CS_N_IN, 8))
		else $error("output started too early");
	a_addr_idle_hold: assert property (CS_N_IN [*5] |-> $stable(MEM_ADDR_OUT))
		else $error("address moved while deselected");
endmodule
bind sfr_core sfr_core_sva u_sva (
	.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .CS_N_IN(CS_N_IN), .DQ_OE_OUT(DQ_OE_OUT),
	.MEM_ADDR_OUT(MEM_ADDR_OUT), .WEL_OUT(WEL_OUT), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT)
);

// *** verification/tb_serial_flash_read_wel_regread.sv ***
// tb_serial_flash_read_wel_regread.sv: self-checking bench for the flash front end
`timescale 1ns/1ps
`include "sfr_defs.svh"
module tb_serial_flash_read_wel_regread;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        busy = 1'b0;
	logic        perr = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, mem_addr;
	logic        pready, pslverr, wel, sck, cs_n;
	logic [3:0]  dq_d, oe_d, dq_h, oe_h;
	wire  [3:0]  dq_w;
	int          err_count = 0;
	int          cmp_count = 0;
	// clock; the data lines carry pull-ups
	always #10 clk = ~clk;
	assign dq_w = (oe_d & dq_d) | (~oe_d & oe_h & dq_h) | (~oe_d & ~oe_h);
	sfr_core dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .SCK_IN(sck), .CS_N_IN(cs_n), .DQ_IN(dq_w),
		.DQ_OUT(dq_d), .DQ_OE_OUT(oe_d), .MEM_ADDR_OUT(mem_addr),
		.MEM_DATA_IN(mem_addr[7:0] ^ 8'h5a), .BUSY_IN(busy), .PROT_ERR_SET_IN(perr),
		.WEL_OUT(wel), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr));
	sfr_host_model host (.sck_out(sck), .cs_n_out(cs_n), .dq_out(dq_h), .dq_oe_out(oe_h),
		.dq_in(dq_w));
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// a bare command on 2**p lines
	task cmd(input logic [7:0] op, input int p);
		host.open_f();
		host.put({op, 24'h0}, 8, p, 0);
		host.close_f();
	endtask
	task t_regs();
		logic [31:0] d;
		logic        e;
		logic [7:0]  a [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
		logic [31:0] x [9] = '{`SFR_CTRL_RST, `SFR_STAT_RST, `SFR_FLAG_RST, `SFR_NVCR_RST,
			`SFR_VCR_RST, `SFR_EVCR_RST, `SFR_EAR_RST, 32'h0, 32'h0};
		for (int i = 0; i < 9; i++) begin
			apb(0, a[i], 32'h0, d, e);
			chk("prdata", x[i], d);
			chk("pslverr", i == 8, e);
		end
		apb(1, `SFR_OFF_NVCR, 32'ha5b6, d, e);
		apb(1, `SFR_OFF_EVCR, 32'h6d, d, e);
		apb(1, `SFR_OFF_EAR, 32'h3c, d, e);
		$display("t_regs done");
	endtask
	task t_wel();
		logic [31:0] d;
		logic        e;
		host.open_f();
		host.put({`SFR_OP_WREN, 24'h0}, 8, 0, 0);
		host.dummy(1);
		host.close_f();
		chk("wel", 0, wel);
		for (int p = 0; p < 3; p++) begin
			apb(1, `SFR_OFF_CTRL, 32'h80 | p, d, e);
			cmd(`SFR_OP_WREN, p);
			chk("wel", 1, wel);
			cmd(`SFR_OP_WRDI, p);
			chk("wel", 0, wel);
		end
		apb(1, `SFR_OFF_CTRL, 32'h80, d, e);
		cmd(`SFR_OP_WREN, 0);
		@(posedge clk) perr <= 1'b1;
		@(posedge clk) perr <= 1'b0;
		cmd(`SFR_OP_WRDI, 0);
		chk("wel", 1, wel);
		apb(0, `SFR_OFF_FLAG, 32'h0, d, e);
		chk("flag", 32'h82, d);
		cmd(`SFR_OP_CLRFLAG, 0);
		chk("wel", 0, wel);
		$display("t_wel done");
	endtask
	task t_rreg();
		logic [7:0]  b;
		logic [7:0]  op [6] = '{8'h05, 8'h70, 8'hb5, 8'h85, 8'h65, 8'hc8};
		logic [23:0] ex [6] = '{24'h030303, 24'h808080, 24'hb6a500, 24'hfbfbfb, 24'h6d6d6d,
			24'h3c3c3c};
		cmd(`SFR_OP_WREN, 0);
		@(posedge clk) busy <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			host.open_f();
			host.put({op[k], 24'h0}, 8, 0, 0);
			for (int j = 2; j >= 0; j--) begin
				host.get(b, 0);
				chk("reg byte", ex[k][8 * j +: 8], b);
			end
			host.close_f();
		end
		@(posedge clk) busy <= 1'b0;
		cmd(`SFR_OP_WRDI, 0);
		$display("t_rreg done");
	endtask
	task t_frame();
		logic [31:0] d;
		logic        e;
		logic [19:0] fr [15] = '{20'h00b00, 20'h03b00, 20'h06b00, 20'h0bb10, 20'h0eb20,
			20'h0e720, 20'h00d01, 20'h03d01, 20'h0bd11, 20'h06d01, 20'h0ed21, 20'h1bb10,
			20'h2eb20, 20'h2ed21, 20'h13d11};
		for (int k = 0; k < 15; k++) begin
			apb(1, `SFR_OFF_CTRL, 32'h80 | fr[k][17:16], d, e);
			host.open_f();
			host.put({fr[k][15:8], 24'h0}, 8, fr[k][17:16], 0);
			host.put({24'h5a3c71, 8'h0}, 24, fr[k][7:4], fr[k][0]);
			repeat (10) @(posedge clk);
			d = fr[k][15:8] == 8'he7 ? 32'h5a3c70 : 32'h5a3c71;
			chk("address", d, mem_addr);
			host.close_f();
		end
		// four address bytes: by a four-byte opcode, then by the control mode bit
		for (int k = 0; k < 2; k++) begin
			apb(1, `SFR_OFF_CTRL, k ? 32'h84 : 32'h80, d, e);
			host.open_f();
			host.put({k ? `SFR_OP_FAST : `SFR_OP_FAST4, 24'h0}, 8, 0, 0);
			host.put(32'h5a3c71e8, 32, 0, 0);
			repeat (10) @(posedge clk);
			chk("address", 32'h5a3c71e8, mem_addr);
			host.close_f();
		end
		$display("t_frame done");
	endtask
	task t_data();
		logic [31:0] d;
		logic        e;
		logic [7:0]  b;
		apb(1, `SFR_OFF_CTRL, 32'h80, d, e);
		host.open_f();
		host.put({`SFR_OP_READ, 24'h0}, 8, 0, 0);
		host.put({24'h0001fe, 8'h0}, 24, 0, 0);
		for (int j = 0; j < 3; j++) begin
			host.get(b, 0);
			chk("read byte", 8'(8'hfe + j) ^ 8'h5a, b);
		end
		host.close_f();
		host.open_f();
		host.put({`SFR_OP_QOUT, 24'h0}, 8, 0, 0);
		host.put({24'h000040, 8'h0}, 24, 0, 0);
		host.dummy(8);
		for (int j = 0; j < 2; j++) begin
			host.get(b, 2);
			chk("quad byte", 8'(8'h40 + j) ^ 8'h5a, b);
		end
		host.close_f();
		$display("t_data done");
	endtask
	task results();
		$display("checks %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_wel();
		t_rreg();
		t_frame();
		t_data();
		results();
	end
	// watchdog cuts a hang short
	initial begin
		#1500000;
		err_count++;
		results();
	end
endmodule
